// [shared/sfexm_pkg.sv]
// Shared constants and types for the vector exception classification block
package sfexm_pkg;
  // Exception flag positions in every six-bit mask
  localparam int EXC_INVALID = 0;
  localparam int EXC_DENORMAL = 1;
  localparam int EXC_DIVZERO = 2;
  localparam int EXC_OVERFLOW = 3;
  localparam int EXC_UNDERFLOW = 4;
  localparam int EXC_PRECISION = 5;
  localparam int EXC_W = 6;
  localparam int OP_W = 6;

  // Permitted exception sets
  localparam logic [5:0] MASK_NONE = 6'h00;
  localparam logic [5:0] MASK_INV_DEN = 6'h03;
  localparam logic [5:0] MASK_INV_PREC = 6'h21;
  localparam logic [5:0] MASK_PREC = 6'h20;
  localparam logic [5:0] MASK_ARITH = 6'h3B;
  localparam logic [5:0] MASK_ALL = 6'h3F;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;
  localparam logic [3:0] REG_DROPPED = 4'hC;
  localparam int ADDR_W = 4;

  // Reset values
  localparam logic [5:0] CTRL_RESET = 6'h3F;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [15:0] DROPPED_RESET = 16'h0000;

  // Field positions in the last-decode register
  localparam int LAST_MASK_LSB = 0;
  localparam int LAST_OP_LSB = 8;
  localparam int LAST_KNOWN_BIT = 16;

  typedef enum logic [5:0] {
    OP_STORE_FP_CONTROL_WORD = 6'h00,
    OP_PACKED_SINGLE_SUB = 6'h01,
    OP_SCALAR_SINGLE_SUB = 6'h02,
    OP_UNORDERED_SINGLE_COMPARE = 6'h03,
    OP_SINGLE_HIGH_INTERLEAVE = 6'h04,
    OP_SINGLE_LOW_INTERLEAVE = 6'h05,
    OP_SINGLE_BITWISE_XOR = 6'h06,
    OP_PACKED_DOUBLE_ADD = 6'h07,
    OP_SCALAR_DOUBLE_ADD = 6'h08,
    OP_DOUBLE_INVERTED_AND = 6'h09,
    OP_DOUBLE_BITWISE_AND = 6'h0A,
    OP_PACKED_DOUBLE_PREDICATE_COMPARE = 6'h0B,
    OP_SCALAR_DOUBLE_PREDICATE_COMPARE = 6'h0C,
    OP_ORDERED_DOUBLE_COMPARE = 6'h0D,
    OP_INT_TO_SINGLE_PACKED = 6'h0E,
    OP_SINGLE_TO_INT_ROUNDED = 6'h0F,
    OP_SINGLE_TO_INT_TRUNCATED = 6'h10,
    OP_INT_TO_DOUBLE_PACKED = 6'h11,
    OP_DOUBLE_TO_INT_ROUNDED = 6'h12,
    OP_DOUBLE_TO_LEGACY_INT_ROUNDED = 6'h13,
    OP_DOUBLE_TO_SINGLE_PACKED = 6'h14,
    OP_LEGACY_INT_TO_DOUBLE = 6'h15,
    OP_SINGLE_TO_DOUBLE_PACKED = 6'h16,
    OP_DOUBLE_TO_GPR_INT_ROUNDED = 6'h17,
    OP_DOUBLE_TO_SINGLE_SCALAR = 6'h18,
    OP_GPR_INT_TO_DOUBLE = 6'h19,
    OP_SINGLE_TO_DOUBLE_SCALAR = 6'h1A,
    OP_DOUBLE_TO_INT_TRUNCATED = 6'h1B,
    OP_DOUBLE_TO_LEGACY_INT_TRUNCATED = 6'h1C,
    OP_DOUBLE_TO_GPR_INT_TRUNCATED = 6'h1D,
    OP_PACKED_DOUBLE_DIVIDE = 6'h1E,
    OP_SCALAR_DOUBLE_DIVIDE = 6'h1F,
    OP_PACKED_DOUBLE_MAXIMUM = 6'h20,
    OP_SCALAR_DOUBLE_MAXIMUM = 6'h21,
    OP_PACKED_DOUBLE_MINIMUM = 6'h22,
    OP_SCALAR_DOUBLE_MINIMUM = 6'h23,
    OP_ALIGNED_DOUBLE_MOVE = 6'h24,
    OP_HIGH_DOUBLE_MOVE = 6'h25,
    OP_LOW_DOUBLE_MOVE = 6'h26,
    OP_DOUBLE_SIGN_EXTRACT = 6'h27,
    OP_SCALAR_DOUBLE_MOVE = 6'h28,
    OP_UNALIGNED_DOUBLE_MOVE = 6'h29,
    OP_PACKED_DOUBLE_MULTIPLY = 6'h2A,
    OP_SCALAR_DOUBLE_MULTIPLY = 6'h2B
  } sfexm_op_t;
endpackage

// [rtl/sfexm_top.sv]
// Exception permission classifier with flag gating and register slave
//
// Contract
// - Unordered single low compare may report only invalid and denormal.
// - Single interleaves never raise any exception.
// - Double add, packed and scalar: all but divide-by-zero.
// - Double AND and inverted AND are pure bit operations, no exceptions.
// - Double predicate compares may report only invalid and denormal.
// - Ordered double low compare may report only invalid and denormal.
// - Four integers to single may raise only precision.
// - Rounded float to integer conversions may raise only invalid and precision.
// - Truncating float to integer conversions may raise only invalid and precision.
// - Two integers to double from vector register never raise exceptions.
// - Legacy register integers to double raise no exception.
// - General register integer to double raises no exception.
// - Packed double to single narrowing: all but divide-by-zero.
// - Scalar double to single narrowing: all but divide-by-zero.
// - Packed single to double widening: only invalid and denormal.
// - Scalar single to double widening: only invalid and denormal.
// - Double divide, packed and scalar, may raise all six.
// - Double maximum and minimum: only invalid and denormal.
// - Double moves of every kind never raise exceptions.
// - Double sign extraction never raises exceptions.
// - Double multiply, packed and scalar: all but divide-by-zero.
module sfexm_top
  import sfexm_pkg::*;
#(
  parameter int DROP_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dec_valid,
  input wire logic [OP_W-1:0] dec_op,
  input wire logic exe_valid,
  input wire logic [EXC_W-1:0] exe_flags,
  output logic [EXC_W-1:0] allow_mask,
  output logic allow_valid,
  output logic [EXC_W-1:0] exc_flags,
  output logic exc_valid
);

  logic [EXC_W-1:0] ctrl_enable_r;
  logic [EXC_W-1:0] status_r;
  logic [EXC_W-1:0] last_mask_r;
  logic [OP_W-1:0] last_op_r;
  logic last_known_r;
  logic [DROP_W-1:0] dropped_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [EXC_W-1:0] mask_r;
  logic mask_valid_r;
  logic [EXC_W-1:0] flags_r;
  logic flags_valid_r;
  logic bus_req;
  logic bus_done;
  logic [EXC_W-1:0] dec_mask;
  logic [EXC_W-1:0] gated;
  logic [EXC_W-1:0] status_clr;

  function automatic logic op_known(input logic [OP_W-1:0] op);
    op_known = (op <= OP_SCALAR_DOUBLE_MULTIPLY);
  endfunction

  // Permitted exception set for one opcode
  function automatic logic [EXC_W-1:0] op_mask(input logic [OP_W-1:0] op);
    case (op)
      OP_PACKED_SINGLE_SUB, OP_SCALAR_SINGLE_SUB:
        op_mask = MASK_ARITH;
      OP_UNORDERED_SINGLE_COMPARE:
        op_mask = MASK_INV_DEN;
      OP_SINGLE_HIGH_INTERLEAVE, OP_SINGLE_LOW_INTERLEAVE:
        op_mask = MASK_NONE;
      OP_PACKED_DOUBLE_ADD, OP_SCALAR_DOUBLE_ADD:
        op_mask = MASK_ARITH;
      OP_DOUBLE_INVERTED_AND, OP_DOUBLE_BITWISE_AND, OP_SINGLE_BITWISE_XOR:
        op_mask = MASK_NONE;
      OP_PACKED_DOUBLE_PREDICATE_COMPARE, OP_SCALAR_DOUBLE_PREDICATE_COMPARE:
        op_mask = MASK_INV_DEN;
      OP_ORDERED_DOUBLE_COMPARE:
        op_mask = MASK_INV_DEN;
      OP_INT_TO_SINGLE_PACKED:
        op_mask = MASK_PREC;
      OP_SINGLE_TO_INT_ROUNDED, OP_DOUBLE_TO_INT_ROUNDED,
      OP_DOUBLE_TO_LEGACY_INT_ROUNDED, OP_DOUBLE_TO_GPR_INT_ROUNDED:
        op_mask = MASK_INV_PREC;
      OP_SINGLE_TO_INT_TRUNCATED, OP_DOUBLE_TO_INT_TRUNCATED,
      OP_DOUBLE_TO_LEGACY_INT_TRUNCATED, OP_DOUBLE_TO_GPR_INT_TRUNCATED:
        op_mask = MASK_INV_PREC;
      OP_INT_TO_DOUBLE_PACKED:
        op_mask = MASK_NONE;
      OP_LEGACY_INT_TO_DOUBLE:
        op_mask = MASK_NONE;
      OP_GPR_INT_TO_DOUBLE:
        op_mask = MASK_NONE;
      OP_DOUBLE_TO_SINGLE_PACKED:
        op_mask = MASK_ARITH;
      OP_DOUBLE_TO_SINGLE_SCALAR:
        op_mask = MASK_ARITH;
      OP_SINGLE_TO_DOUBLE_PACKED:
        op_mask = MASK_INV_DEN;
      OP_SINGLE_TO_DOUBLE_SCALAR:
        op_mask = MASK_INV_DEN;
      OP_PACKED_DOUBLE_DIVIDE, OP_SCALAR_DOUBLE_DIVIDE:
        op_mask = MASK_ALL;
      OP_PACKED_DOUBLE_MAXIMUM, OP_SCALAR_DOUBLE_MAXIMUM,
      OP_PACKED_DOUBLE_MINIMUM, OP_SCALAR_DOUBLE_MINIMUM:
        op_mask = MASK_INV_DEN;
      OP_ALIGNED_DOUBLE_MOVE, OP_HIGH_DOUBLE_MOVE, OP_LOW_DOUBLE_MOVE,
      OP_SCALAR_DOUBLE_MOVE, OP_UNALIGNED_DOUBLE_MOVE:
        op_mask = MASK_NONE;
      OP_DOUBLE_SIGN_EXTRACT:
        op_mask = MASK_NONE;
      OP_PACKED_DOUBLE_MULTIPLY, OP_SCALAR_DOUBLE_MULTIPLY:
        op_mask = MASK_ARITH;
      // control word store and unknown codes empty
      default:
        op_mask = MASK_NONE;
    endcase
  endfunction

  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~waitreq_r;
  assign dec_mask = op_mask(dec_op) & ctrl_enable_r;
  assign gated = exe_flags & mask_r;

  always_comb begin
    status_clr = '0;
    if (avs_write && bus_done && avs_address == REG_STATUS && avs_byteenable[0]) begin
      status_clr = avs_writedata[EXC_W-1:0];
    end
  end

  // One wait cycle per access, then completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
    end else if (bus_req && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && waitreq_r) begin
      case (avs_address)
        REG_CTRL: rdata_r <= {26'h000_0000, ctrl_enable_r};
        REG_STATUS: rdata_r <= {26'h000_0000, status_r};
        REG_LAST: rdata_r <= {15'h0000, last_known_r, 2'h0, last_op_r,
                              2'h0, last_mask_r};
        REG_DROPPED: rdata_r <= 32'(dropped_r);
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_enable_r <= CTRL_RESET;
    end else if (avs_write && bus_done && avs_address == REG_CTRL && avs_byteenable[0]) begin
      ctrl_enable_r <= avs_writedata[EXC_W-1:0];
    end
  end

  // Sticky gated flags; a new flag beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= (status_r & ~status_clr) | (exe_valid ? gated : MASK_NONE);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dropped_r <= '0;
    end else if (avs_write && bus_done && avs_address == REG_DROPPED) begin
      dropped_r <= '0;
    end else if (exe_valid && (exe_flags & ~mask_r) != MASK_NONE && ~&dropped_r) begin
      dropped_r <= dropped_r + 1'b1;
    end
  end

  // mask presented one cycle after decode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_NONE;
      mask_valid_r <= 1'b0;
    end else begin
      mask_valid_r <= dec_valid;
      if (dec_valid) begin
        mask_r <= dec_mask;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_mask_r <= MASK_NONE;
      last_op_r <= '0;
      last_known_r <= 1'b0;
    end else if (dec_valid) begin
      last_mask_r <= dec_mask;
      last_op_r <= dec_op;
      last_known_r <= op_known(dec_op);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= MASK_NONE;
      flags_valid_r <= 1'b0;
    end else begin
      flags_valid_r <= exe_valid;
      flags_r <= exe_valid ? gated : MASK_NONE;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = waitreq_r;
  assign allow_mask = mask_r;
  assign allow_valid = mask_valid_r;
  assign exc_flags = flags_r;
  assign exc_valid = flags_valid_r;

endmodule

// [verification/sfexm_pipe_model.sv]
// Behavioural decoder and execution pipeline feeding the classifier
module sfexm_pipe_model (
  input wire logic ref_clk,
  output logic dec_valid,
  output logic [5:0] dec_op,
  output logic exe_valid,
  output logic [5:0] exe_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dec_valid = 1'h0;
    dec_op = 6'h15;
    exe_valid = 1'h0;
    exe_flags = 6'h2A;
  end
  // Unqualified lines show the inverse of the last value
  task automatic dec(input logic [5:0] op);
    @(posedge ref_clk);
    dec_valid <= 1'h1;
    dec_op <= op;
    @(posedge ref_clk);
    dec_valid <= 1'h0;
    dec_op <= ~op;
  endtask
  task automatic exe(input logic [5:0] fl);
    @(posedge ref_clk);
    exe_valid <= 1'h1;
    exe_flags <= fl;
    @(posedge ref_clk);
    exe_valid <= 1'h0;
    exe_flags <= ~fl;
  endtask
endmodule

// [verification/sfexm_chk.sv]
// Concurrent checks on the classifier ports
module sfexm_chk
  import sfexm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic dec_valid,
  input wire logic [OP_W-1:0] dec_op,
  input wire logic exe_valid,
  input wire logic [EXC_W-1:0] exe_flags,
  input wire logic [EXC_W-1:0] allow_mask,
  input wire logic allow_valid,
  input wire logic [EXC_W-1:0] exc_flags,
  input wire logic exc_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_grant;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_dec(logic hit);
    dec_valid && hit;
  endsequence
  a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_grant)
    else $error("bus wait not one cycle");
  a_allow_pulse: assert property (dec_valid |=> allow_valid)
    else $error("allow_valid missing");
  a_allow_idle: assert property (!dec_valid |=> !allow_valid)
    else $error("allow_valid without decode");
  a_mask_hold: assert property (!dec_valid |=> $stable(allow_mask))
    else $error("allow_mask moved without decode");
  a_exc_gate: assert property (exe_valid |=> exc_valid && exc_flags ==
    ($past(exe_flags) & $past(allow_mask))) else $error("exc_flags not gated");
  a_exc_idle: assert property (!exc_valid |-> exc_flags == 6'h00)
    else $error("exc_flags set while idle");
  a_no_divzero: assert property (s_dec(dec_op inside {6'h07, 6'h08, 6'h14, 6'h18,
    6'h2A, 6'h2B}) |=> !allow_mask[EXC_DIVZERO]) else $error("divide-by-zero allowed");
  a_empty_mask: assert property (s_dec(dec_op inside {[6'h04:6'h06], 6'h09, 6'h0A,
    6'h11, 6'h15, 6'h19, [6'h24:6'h29]}) |=> allow_mask == 6'h00) else $error("mask not empty");
  a_inv_den: assert property (s_dec(dec_op inside {6'h03, [6'h0B:6'h0D], 6'h16, 6'h1A,
    [6'h20:6'h23]}) |=> (allow_mask & ~MASK_INV_DEN) == 6'h00) else $error("mask beyond inv den");
  a_inv_prec: assert property (s_dec(dec_op inside {6'h0F, 6'h10, 6'h12, 6'h13, 6'h17,
    [6'h1B:6'h1D]}) |=> (allow_mask & ~MASK_INV_PREC) == 6'h00) else $error("mask beyond inv prec");
endmodule
bind sfexm_top sfexm_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .dec_valid(dec_valid),
  .dec_op(dec_op), .exe_valid(exe_valid), .exe_flags(exe_flags), .allow_mask(allow_mask),
  .allow_valid(allow_valid), .exc_flags(exc_flags), .exc_valid(exc_valid));

// [verification/simd_fp_exception_map_tb.sv]
// Self-checking bench for the exception classifier
module simd_fp_exception_map_tb
  import sfexm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  logic dec_valid;
  logic exe_valid;
  logic allow_valid;
  logic exc_valid;
  logic [5:0] dec_op;
  logic [5:0] exe_flags;
  logic [5:0] allow_mask;
  logic [5:0] exc_flags;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  sfexm_top #(.DROP_W(16)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dec_valid(dec_valid), .dec_op(dec_op), .exe_valid(exe_valid), .exe_flags(exe_flags),
    .allow_mask(allow_mask), .allow_valid(allow_valid), .exc_flags(exc_flags),
    .exc_valid(exc_valid));
  sfexm_pipe_model pm (.ref_clk(ref_clk), .dec_valid(dec_valid), .dec_op(dec_op),
    .exe_valid(exe_valid), .exe_flags(exe_flags));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    // Hold the request until waitrequest is sampled low at a rising edge
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
    av(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  function automatic logic [5:0] exp_mask(input logic [5:0] op);
    case (op) inside
      6'h01, 6'h02, 6'h07, 6'h08, 6'h14, 6'h18, 6'h2A, 6'h2B: exp_mask = MASK_ARITH;
      6'h03, [6'h0B:6'h0D], 6'h16, 6'h1A, [6'h20:6'h23]: exp_mask = MASK_INV_DEN;
      6'h0F, 6'h10, 6'h12, 6'h13, 6'h17, [6'h1B:6'h1D]: exp_mask = MASK_INV_PREC;
      6'h0E: exp_mask = MASK_PREC;
      6'h1E, 6'h1F: exp_mask = MASK_ALL;
      default: exp_mask = MASK_NONE;
    endcase
  endfunction
  task automatic run(input logic [5:0] op, input logic [5:0] fl, input logic [5:0] exp);
    pm.dec(op);
    #1;
    chk("allow_valid", 32'h1, 32'(allow_valid));
    chk("allow_mask", 32'(exp), 32'(allow_mask));
    pm.exe(fl);
    #1;
    chk("exc_valid", 32'h1, 32'(exc_valid));
    chk("exc_flags", 32'(exp & fl), 32'(exc_flags));
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rchk("ctrl", REG_CTRL, 32'(CTRL_RESET));
    rchk("status", REG_STATUS, 32'(STATUS_RESET));
    rchk("last", REG_LAST, 32'h0);
    rchk("dropped", REG_DROPPED, 32'(DROPPED_RESET));
    rchk("unmapped", 4'h2, 32'h0);
    for (int i = 0; i < 64; i++) begin
      run(6'(i), 6'h3F, exp_mask(6'(i)));
    end
    rchk("last", REG_LAST, 32'h0000_3F00);
    rchk("status", REG_STATUS, 32'h0000_003F);
    rchk("dropped", REG_DROPPED, 32'h0000_003E);
    av(1'h1, REG_STATUS, 32'h0000_0005);
    rchk("status", REG_STATUS, 32'h0000_003A);
    av(1'h1, REG_DROPPED, 32'h0);
    av(1'h1, REG_CTRL, 32'h0000_0001);
    run(6'h1F, 6'h3F, 6'h01);
    rchk("last", REG_LAST, 32'h0001_1F01);
    rchk("dropped", REG_DROPPED, 32'h0000_0001);
    stop_test();
  end
endmodule
